// File: src/cmrt_top.v
// Compare match request timer with AHB-Lite register slave
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "cmrt_defs.vh"
module cmrt_top (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	input wire standby,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,
	output reg dma_request
);
	reg run_bit;
	reg match_flag;
	reg bit6;
	reg [1:0] tick_select;
	reg [15:0] match_constant;
	reg flag_seen;
	reg wr_pend;
	reg [3:0] wr_addr;
	reg standby_meta;
	reg standby_sync;
	wire tick;
	wire match;
	wire [15:0] match_counter;
	wire addr_phase;
	wire cnt_load;
	wire flag_clear;
	wire [15:0] csr_value;
	reg [31:0] next_hrdata;

	function [31:0] cmrt_read;
		input [3:0] addr;
		input [15:0] csr;
		input [15:0] cnt;
		input [15:0] cor;
		input run;
		begin
			case (addr)
				`CMRT_ADDR_START: cmrt_read = {{31{1'b0}}, run};
				`CMRT_ADDR_CSR: cmrt_read = {16'h0000, csr};
				`CMRT_ADDR_CNT: cmrt_read = {16'h0000, cnt};
				`CMRT_ADDR_COR: cmrt_read = {16'h0000, cor};
				default: cmrt_read = 32'h00000000;
			endcase
		end
	endfunction

	assign addr_phase = hsel && hready && htrans[1];
	assign csr_value = {8'h00, match_flag, bit6, 4'h0, tick_select};
	assign cnt_load = wr_pend && (wr_addr == `CMRT_ADDR_CNT);
	assign flag_clear = wr_pend && (wr_addr == `CMRT_ADDR_CSR) && flag_seen
		&& !hwdata[`CMRT_FLAG_BIT];

	cmrt_prescaler #(
		.WIDTH(`CMRT_PRE_WIDTH)
	) u_prescaler (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick_select(tick_select),
		.tick(tick)
	);

	cmrt_counter #(
		.WIDTH(16)
	) u_counter (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(run_bit && !standby_sync),
		.tick(tick),
		.constant(match_constant),
		.load(cnt_load),
		.load_value(hwdata[15:0]),
		.count(match_counter),
		.match(match)
	);

	always @* begin
		next_hrdata = hrdata;
		if (addr_phase && !hwrite) begin
			next_hrdata = cmrt_read(haddr[3:0], csr_value, match_counter,
				match_constant, run_bit);
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_bit <= 1'b0;
			match_flag <= 1'b0;
			bit6 <= 1'b0;
			tick_select <= `CMRT_SEL_DIV4;
			match_constant <= `CMRT_COR_RESET;
			flag_seen <= 1'b0;
			wr_pend <= 1'b0;
			wr_addr <= 4'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			standby_meta <= 1'b0;
			standby_sync <= 1'b0;
			dma_request <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= next_hrdata;
			wr_pend <= addr_phase && hwrite;
			// Standby pin synchroniser
			standby_meta <= standby;
			standby_sync <= standby_meta;
			if (addr_phase) begin
				wr_addr <= haddr[3:0];
			end
			dma_request <= match;
			if (addr_phase && !hwrite && haddr[3:0] == `CMRT_ADDR_CSR
				&& match_flag) begin
				flag_seen <= 1'b1;
			end
			if (wr_pend) begin
				case (wr_addr)
					`CMRT_ADDR_START: run_bit <= hwdata[`CMRT_RUN_BIT];
					`CMRT_ADDR_CSR: begin
						bit6 <= hwdata[`CMRT_CSR_BIT6];
						tick_select <= hwdata[`CMRT_SEL_HI:`CMRT_SEL_LO];
					end
					`CMRT_ADDR_COR: match_constant <= hwdata[15:0];
					default: begin
					end
				endcase
			end
			if (match) begin
				match_flag <= 1'b1;
			end else if (flag_clear) begin
				match_flag <= 1'b0;
				flag_seen <= 1'b0;
			end
		end
	end
endmodule // cmrt_top

// File: src/cmrt_defs.vh
// Constants for the compare match request timer
`ifndef CMRT_DEFS_VH
`define CMRT_DEFS_VH
`define CMRT_ADDR_START 4'h0
`define CMRT_ADDR_CSR 4'h4
`define CMRT_ADDR_CNT 4'h8
`define CMRT_ADDR_COR 4'hC
`define CMRT_RUN_BIT 0
`define CMRT_FLAG_BIT 7
`define CMRT_CSR_BIT6 6
`define CMRT_SEL_HI 1
`define CMRT_SEL_LO 0
`define CMRT_CNT_RESET 16'h0000
`define CMRT_COR_RESET 16'hFFFF
`define CMRT_CSR_RESET 16'h0000
`define CMRT_SEL_DIV4 2'h0
`define CMRT_SEL_DIV8 2'h1
`define CMRT_SEL_DIV16 2'h2
`define CMRT_SEL_DIV64 2'h3
`define CMRT_PRE_DIV4 3'h1
`define CMRT_PRE_DIV8 3'h2
`define CMRT_PRE_DIV16 3'h3
`define CMRT_PRE_DIV64 3'h5
`define CMRT_PRE_WIDTH 6
`define CMRT_HTRANS_NONSEQ 2'h2
`define CMRT_HTRANS_SEQ 2'h3
`endif

// File: src/cmrt_prescaler.v
// Free running prescaler producing one-cycle tick enables
`timescale 1ns/1ps
`include "cmrt_defs.vh"
module cmrt_prescaler #(
	parameter WIDTH = `CMRT_PRE_WIDTH
) (
	input wire hclk,
	input wire hresetn,
	input wire [1:0] tick_select,
	output reg tick
);
	reg [WIDTH-1:0] div;
	reg [WIDTH-1:0] next_div;
	reg next_tick;
	always @* begin
		next_div = div + {{(WIDTH-1){1'b0}}, 1'b1};
		case (tick_select)
			`CMRT_SEL_DIV4: next_tick = &next_div[`CMRT_PRE_DIV4:0];
			`CMRT_SEL_DIV8: next_tick = &next_div[`CMRT_PRE_DIV8:0];
			`CMRT_SEL_DIV16: next_tick = &next_div[`CMRT_PRE_DIV16:0];
			`CMRT_SEL_DIV64: next_tick = &next_div[`CMRT_PRE_DIV64:0];
			default: next_tick = 1'b0;
		endcase
	end
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div <= {WIDTH{1'b0}};
			tick <= 1'b0;
		end else begin
			div <= next_div;
			tick <= next_tick;
		end
	end
endmodule // cmrt_prescaler

// File: src/cmrt_counter.v
// Sixteen-bit match counter with write override
`timescale 1ns/1ps
`include "cmrt_defs.vh"
module cmrt_counter #(
	parameter WIDTH = 16
) (
	input wire hclk,
	input wire hresetn,
	input wire run,
	input wire tick,
	input wire [WIDTH-1:0] constant,
	input wire load,
	input wire [WIDTH-1:0] load_value,
	output reg [WIDTH-1:0] count,
	output reg match
);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= `CMRT_CNT_RESET;
			match <= 1'b0;
		end else begin
			match <= 1'b0;
			if (load) begin
				count <= load_value;
			end else if (run && tick) begin
				if (count == constant) begin
					count <= {WIDTH{1'b0}};
					match <= 1'b1;
				end else begin
					count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // cmrt_counter

// File: testbench/cmrt_assertions.sv
// Checker on the timer's bus and request ports
`timescale 1ns/1ps
module cmrt_checker (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire dma_request
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire rd = hsel && htrans[1] && !hwrite && hready;
	reg seen;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			seen <= 1'b0;
		else if (dma_request)
			seen <= 1'b1;
	end
	req_pulse_a: assert property (dma_request |=> !dma_request)
		else $error("request longer than a cycle");
	req_space_a: assert property ($fell(dma_request) |-> !dma_request[*3])
		else $error("requests closer than four cycles");
	idle_start_a: assert property ($rose(hresetn) |-> !dma_request[*4])
		else $error("request while stopped");
	csr_resv_a: assert property ($past(rd && haddr[3:0] == 4'h4) |->
		hrdata[15:8] == 8'h00 && hrdata[5:2] == 4'h0) else $error("reserved bits set");
	start_resv_a: assert property ($past(rd && haddr[3:0] == 4'h0) |->
		hrdata[15:1] == 15'h0000) else $error("start upper bits set");
	upper_zero_a: assert property ($past(rd) |-> hrdata[31:16] == 16'h0000)
		else $error("upper half set");
	flag_clean_a: assert property ($past(rd && haddr[3:0] == 4'h4) && !seen &&
		!dma_request |-> !hrdata[7]) else $error("flag set before any match");
	bus_ok_a: assert property (hreadyout && !hresp) else $error("wait or error response");
endmodule // cmrt_checker

// File: testbench/cmrt_dma_model.sv
// Request consumer in place of the DMA channel
`timescale 1ns/1ps
module cmrt_dma_model (
	input wire hclk,
	input wire hresetn,
	input wire dma_request,
	output int taken
);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			taken <= 0;
		else if (dma_request)
			taken <= taken + 1;
	end
endmodule // cmrt_dma_model

// File: testbench/cmrt_top_tb.sv
// Self-checking bench for the timer
`timescale 1ns/1ps
module cmrt_top_tb;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, standby = 0, dp_rd = 0;
	logic [31:0] haddr = 0, hwdata = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [15:0] c, exp_q[$];
	wire hreadyout, hresp, dma_request;
	wire [31:0] hrdata;
	int bad_count = 0, checked = 0, taken, n;
	cmrt_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .standby(standby), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .dma_request(dma_request));
	cmrt_dma_model dma (.hclk(hclk), .hresetn(hresetn), .dma_request(dma_request),
		.taken(taken));
	initial forever #10 hclk = ~hclk;
	task stop_test;
		$display("mismatches %0d checks %0d", bad_count, checked);
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task fail(input string m);
		bad_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task wait_for(input logic w, input int lim);
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while ((w ? dma_request : hreadyout) !== 1'b1 && n < lim);
		if (n >= lim) begin
			fail("wait ran out");
			stop_test;
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {28'h0, a};
		wait_for(0, 50);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		wait_for(0, 50);
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		bus(0, a, 16'h0);
	endtask
	always @(posedge hclk) begin
		dp_rd <= hsel && htrans[1] && !hwrite;
		if (dp_rd && hreadyout) begin
			checked++;
			if (hrdata !== {16'h0, exp_q[0]})
				fail("read data wrong");
			void'(exp_q.pop_front());
		end
	end
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1;
		void'($urandom(65188));
		rd(4'h0, 16'h0000);
		rd(4'h4, 16'h0000);
		rd(4'h8, 16'h0000);
		rd(4'hC, 16'hFFFF);
		bus(1, 4'h4, 16'hFFFF);
		rd(4'h4, 16'h0043);
		for (int s = 0; s < 4; s++) begin
			c = 16'($urandom % 4 + 1);
			bus(1, 4'h4, 16'(s));
			bus(1, 4'hC, c);
			bus(1, 4'h8, 16'h0000);
			bus(1, 4'h0, 16'h0001);
			wait_for(1, 2000);
			wait_for(1, 2000);
			checked++;
			// period of c plus one ticks
			if (n != (c + 1) * (s == 3 ? 64 : 4 << s))
				fail("match period wrong");
		end
		bus(1, 4'h0, 16'hFFFE);
		rd(4'h0, 16'h0000);
		bus(1, 4'h8, 16'h1234);
		repeat (300) @(posedge hclk);
		rd(4'h8, 16'h1234);
		rd(4'h4, 16'h0083);
		bus(1, 4'h4, 16'h0003);
		rd(4'h4, 16'h0003);
		checked++;
		if (taken < 8)
			fail("requests missing");
		hresetn <= 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1;
		rd(4'h8, 16'h0000);
		rd(4'h4, 16'h0000);
		rd(4'hC, 16'hFFFF);
		bus(1, 4'hC, 16'h0000);
		bus(1, 4'h0, 16'h0001);
		wait_for(1, 50);
		wait_for(1, 50);
		rd(4'h4, 16'h0080);
		wait_for(1, 50);
		@(posedge hclk);
		bus(1, 4'h4, 16'h0000);
		rd(4'h4, 16'h0080);
		wait_for(1, 50);
		bus(1, 4'h8, 16'h0005);
		rd(4'h8, 16'h0005);
		standby <= 1;
		repeat (4) @(posedge hclk);
		bus(1, 4'h8, 16'h1234);
		repeat (100) @(posedge hclk);
		rd(4'h8, 16'h1234);
		rd(4'h0, 16'h0001);
		standby <= 0;
		stop_test;
	end
endmodule // cmrt_top_tb
bind cmrt_top cmrt_checker chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .dma_request(dma_request));
